// ### bench/vdp_deser_out_tb.sv
/*
  vdp_deser_out_tb.sv: self-checking bench for the parallel video output block.
  Assumes shortened lock counts (8 and 32) and the receiver model beside it.
*/
`timescale 1ns/10ps
`default_nettype none

module vdp_deser_out_tb;
  logic clk_sys_i = 1'b0, rstn_i = 1'b0, ref_clk = 1'b0, rec_clk = 1'b0;
  logic ref_en = 1'b0, rec_en = 1'b0, pdn_n = 1'b0, oe = 1'b0, rise_sel = 1'b0;
  logic [1:0] rng = 2'b00;
  logic [17:0] rx_pix = 18'h0_0000, pix, exp_pix = 18'h0_0000, m_pix;
  logic [8:0] rx_ctl = 9'h000, ctl, exp_ctl = 9'h000, m_ctl;
  logic rx_phase = 1'b0, found = 1'b0, p, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0000_0000, rdata;
  logic irq, flag, pclk, valid_n, oe_n, fast;
  logic [17:0] pix_out;
  logic [8:0] ctl_out;
  int failures = 0, n_checks = 0, i;

  vdp_deser_out #(.REF_LOCK_CYCLES(8), .SEARCH_CYCLES(32)) dut_u (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .reference_clock_i(ref_clk),
    .power_down_n_i(pdn_n), .outputs_drive_enable_i(oe), .latch_rise_sel_i(rise_sel),
    .range_select_hi_i(rng[1]), .range_select_lo_i(rng[0]), .rec_clk_i(rec_clk),
    .rx_pixel_i(rx_pix), .rx_control_i(rx_ctl), .rx_video_phase_i(rx_phase),
    .rx_transition_found_i(found), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata), .irq_o(irq),
    .pixel_word_out_o(pix_out), .control_word_out_o(ctl_out),
    .video_phase_flag_o(flag), .pclk_out_o(pclk), .sync_valid_n_o(valid_n),
    .outputs_oe_n_o(oe_n), .fast_slew_o(fast));

  vdp_rx_model rx_u (.pclk_i(pclk), .rise_sel_i(rise_sel), .valid_n_i(valid_n),
    .flag_i(flag), .pix_i(pix_out), .ctl_i(ctl_out), .pix_o(m_pix), .ctl_o(m_ctl));

  // 250 MHz system clock
  always #2 clk_sys_i = ~clk_sys_i;
  // reference at the pixel rate; odd offsets keep it off system edges
  initial begin
    #5;
    forever #24 ref_clk = ref_en ? ~ref_clk : 1'b0;
  end
  // link clock starts after the first search timeout and then runs to the end
  initial begin
    #7;
    forever #24 rec_clk = rec_en ? ~rec_clk : 1'b0;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic finish_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test

  // a bounded wait that ran out ends the run
  task automatic guard(input logic ok);
    if (ok !== 1'b1) begin
      failures++;
      $display("BAD wait timeout");
      finish_test();
    end
  endtask : guard

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input string nm, input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_sys_i);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd <= 1'b0;
    #1;
    chk(nm, rdata, e);
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : settle

  // new word when its group is active, else the held one
  function automatic logic [17:0] take(input logic en, input logic [17:0] nw,
                                       input logic [17:0] old);
    return en ? nw : old;
  endfunction : take

  initial begin
    void'($urandom(32'h0000_de95));
    repeat (20) @(posedge clk_sys_i);
    chk("oe_n in reset", oe_n, 1'b1);
    chk("lock_n in reset", valid_n, 1'b1);
    rstn_i <= 1'b1;
    settle(5);
    chk("oe_n pins open", oe_n, 1'b1);
    rd("info off", 4'h8, 32'h0000_0001);
    rd("unmapped", 4'hc, 32'h0000_0000);
    wr(4'h4, 32'h0000_0004);
    rd("mask", 4'h4, 32'h0000_0004);
    // range code matches the 48 ns link clock
    rng <= 2'b11;
    oe <= 1'b1;
    ref_en <= 1'b1;
    pdn_n <= 1'b1;
    for (i = 0; i < 20 && pclk !== 1'b1; i++) settle(1);
    guard(pclk === 1'b1);
    for (i = 0; i < 20 && pclk !== 1'b0; i++) settle(1);
    guard(pclk === 1'b0);
    for (i = 0; i < 3000 && irq !== 1'b1; i++) settle(1);
    guard(irq === 1'b1);
    chk("lock_n search", valid_n, 1'b1);
    chk("pix search", pix_out, 18'h0_0000);
    chk("oe_n driving", oe_n, 1'b0);
    rd("status tmo", 4'h0, 32'h0000_0004);
    settle(2);
    chk("irq cleared", irq, 1'b0);
    rd("info search", 4'h8, 32'h0000_0054);
    rec_en <= 1'b1;
    found <= 1'b1;
    for (i = 0; i < 300 && valid_n !== 1'b0; i++) settle(1);
    guard(valid_n === 1'b0);
    for (int s = 0; s < 2; s++) begin
      rise_sel <= s[0];
      for (int k = 0; k < 8; k++) begin
        p = (k < 2) ? k[0] : 1'($urandom);
        pix = 18'($urandom);
        ctl = 9'($urandom);
        @(posedge rec_clk);
        @(posedge clk_sys_i);
        rx_pix <= pix;
        rx_ctl <= ctl;
        rx_phase <= p;
        repeat (3) @(posedge rec_clk);
        settle(1);
        exp_pix = take(p, pix, exp_pix);
        exp_ctl = 9'(take(!p, 18'(ctl), 18'(exp_ctl)));
        chk("phase flag", flag, p);
        chk("pixel word", pix_out, exp_pix);
        chk("control word", ctl_out, exp_ctl);
        chk("rx pixel", m_pix, exp_pix);
        chk("rx control", m_ctl, exp_ctl);
      end
    end
    rd("status lock", 4'h0, 32'h0000_0001);
    rng <= 2'b10;
    settle(6);
    chk("slow slew", fast, 1'b0);
    wr(4'h4, 32'h0000_0008);
    rng <= 2'b01;
    settle(6);
    chk("irq bad range", irq, 1'b1);
    rd("status range", 4'h0, 32'h0000_0008);
    settle(2);
    chk("irq range clr", irq, 1'b0);
    oe <= 1'b0;
    settle(6);
    chk("oe_n disabled", oe_n, 1'b1);
    oe <= 1'b1;
    pdn_n <= 1'b0;
    settle(6);
    chk("oe_n power down", oe_n, 1'b1);
    chk("lock_n power down", valid_n, 1'b1);
    // rising latch edge is still selected, so its info bit stays set
    rd("info power down", 4'h8, 32'h0000_0021);
    finish_test();
  end

  // hard stop for any hang outside the bounded waits
  initial begin
    #300000;
    failures++;
    finish_test();
  end
endmodule : vdp_deser_out_tb

`default_nettype wire

// ### bench/vdp_rx_model.sv
/*
  vdp_rx_model.sv: receiving display logic at the far side of the video outputs.
  Assumes pclk, words and the sync-valid level come straight from the block.
*/
`timescale 1ns/10ps
`default_nettype none

module vdp_rx_model (
  input wire logic pclk_i,
  input wire logic rise_sel_i,
  input wire logic valid_n_i,
  input wire logic flag_i,
  input wire logic [17:0] pix_i,
  input wire logic [8:0] ctl_i,
  output logic [17:0] pix_o,
  output logic [8:0] ctl_o
);
  // nothing captured yet
  initial begin
    pix_o = 18'h0_0000;
    ctl_o = 9'h000;
  end

  always @(pclk_i) begin
    if (pclk_i === rise_sel_i && valid_n_i === 1'b0) begin
      if (flag_i) pix_o <= pix_i;
      else ctl_o <= ctl_i;
    end
  end
endmodule : vdp_rx_model

`default_nettype wire

// ### core/vdp_defines.svh
/*
  vdp_defines.svh: offsets, field positions, reset values and counts of the
  parallel video output block.
  Assumes it is included by bare name, after the package, in core/ sources.
*/
`ifndef VDP_DEFINES_SVH
`define VDP_DEFINES_SVH

// word widths
`define VDP_PIX_W 18
`define VDP_CTL_W 9

// lock timing, in reference clock cycles
`define VDP_REF_LOCK_CYCLES 16385
`define VDP_SEARCH_CYCLES 1048576

// register offsets (byte addresses)
`define VDP_ADDR_W 4
`define VDP_OFS_STATUS 4'h0
`define VDP_OFS_MASK 4'h4
`define VDP_OFS_INFO 4'h8

// status and mask bit positions
`define VDP_EV_W 4
`define VDP_EV_LOCK_GAINED 0
`define VDP_EV_LOCK_LOST 1
`define VDP_EV_SEARCH_TMO 2
`define VDP_EV_RANGE_BAD 3

// info register field positions
`define VDP_INFO_STATE_LSB 0
`define VDP_INFO_FAST_SLEW 4
`define VDP_INFO_RISE_EDGE 5
`define VDP_INFO_DRIVING 6

// reset values
`define VDP_MASK_RST 4'h0
`define VDP_STATUS_RST 4'h0

// range select codes
`define VDP_RNG_SLOW 2'b10
`define VDP_RNG_FAST 2'b11

`endif

// ### core/vdp_deser_out.sv
/*
  vdp_deser_out.sv: parallel output side of a 27-bit video deserializer:
  pixel / control word outputs, pixel clock out, lock indicator, output
  enable, lock sequencing and a small register port with an interrupt.
  Assumes: the serial decoder delivers words, phase and a transition-found
  level on its own recovered clock; pins and that clock arrive unsynchronised
  and are sampled here on clk_sys_i (250 MHz), far faster than 35 MHz.
*/
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "vdp_defines.svh"

module vdp_deser_out #(
  parameter int unsigned REF_LOCK_CYCLES = `VDP_REF_LOCK_CYCLES,
  parameter int unsigned SEARCH_CYCLES = `VDP_SEARCH_CYCLES,
  parameter int unsigned PIX_W = `VDP_PIX_W,
  parameter int unsigned CTL_W = `VDP_CTL_W
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic reference_clock_i,
  input wire logic power_down_n_i,
  input wire logic outputs_drive_enable_i,
  input wire logic latch_rise_sel_i,
  input wire logic range_select_hi_i,
  input wire logic range_select_lo_i,
  input wire logic rec_clk_i,
  input wire logic [PIX_W-1:0] rx_pixel_i,
  input wire logic [CTL_W-1:0] rx_control_i,
  input wire logic rx_video_phase_i,
  input wire logic rx_transition_found_i,
  input wire logic [`VDP_ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output logic irq_o,
  output logic [PIX_W-1:0] pixel_word_out_o,
  output logic [CTL_W-1:0] control_word_out_o,
  output logic video_phase_flag_o,
  output logic pclk_out_o,
  output logic sync_valid_n_o,
  output logic outputs_oe_n_o,
  output logic fast_slew_o
);

  localparam int unsigned SW = 9 + PIX_W + CTL_W;
  localparam int unsigned CW = $clog2(SEARCH_CYCLES + 1);

  logic [SW-1:0] meta_r;
  logic [SW-1:0] sync_r;
  logic s_ref, s_rec, s_pd_n, s_en, s_rf, s_rhi, s_rlo, s_video, s_trans;
  logic [PIX_W-1:0] s_pix;
  logic [CTL_W-1:0] s_ctl;
  logic ref_prev_r, rec_prev_r, ref_rise, rec_rise, rec_fall, launch;
  logic [PIX_W-1:0] hold_pix_r, src_pix, pix_r;
  logic [CTL_W-1:0] hold_ctl_r, src_ctl, ctl_r;
  logic hold_video_r, src_video, flag_r, pclk_r, valid_n_r, oe_n_r, slew_r;
  vdp_pkg::vdp_state_t state_r, state_nxt;
  logic [CW-1:0] cnt_r;
  logic locked, timeout, rng_bad, rng_bad_prev_r;
  logic [`VDP_EV_W-1:0] ev, status_r, status_nxt, mask_r;
  logic [31:0] rdata_r;
  logic irq_r;

  // two-flop sampling of every pin and of the decoder's clock domain
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= {reference_clock_i, rec_clk_i, power_down_n_i, outputs_drive_enable_i,
                 latch_rise_sel_i, range_select_hi_i, range_select_lo_i, rx_video_phase_i,
                 rx_transition_found_i, rx_pixel_i, rx_control_i};
      sync_r <= meta_r;
    end
  end

  assign {s_ref, s_rec, s_pd_n, s_en, s_rf, s_rhi, s_rlo, s_video, s_trans, s_pix, s_ctl} =
    sync_r;

  // edge finders on the sampled clocks
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ref_prev_r <= 1'b0;
      rec_prev_r <= 1'b0;
    end else begin
      ref_prev_r <= s_ref;
      rec_prev_r <= s_rec;
    end
  end

  assign ref_rise = s_ref & ~ref_prev_r;
  assign rec_rise = s_rec & ~rec_prev_r;
  assign rec_fall = ~s_rec & rec_prev_r;
  assign launch = s_rf ? rec_fall : rec_rise;
  assign locked = (state_r == vdp_pkg::VDP_ST_LOCKED);
  assign timeout = (state_r == vdp_pkg::VDP_ST_SEARCH) && !s_trans && ref_rise &&
                   (cnt_r == CW'(SEARCH_CYCLES - 1));

  // lock sequence
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      vdp_pkg::VDP_ST_OFF: begin
        state_nxt = vdp_pkg::VDP_ST_REF;
      end
      vdp_pkg::VDP_ST_REF: begin
        if (ref_rise && cnt_r == CW'(REF_LOCK_CYCLES - 1)) begin
          state_nxt = vdp_pkg::VDP_ST_SEARCH;
        end
      end
      vdp_pkg::VDP_ST_SEARCH: begin
        if (s_trans) begin
          state_nxt = vdp_pkg::VDP_ST_LOCKED;
        end
      end
      vdp_pkg::VDP_ST_LOCKED: begin
        if (!s_trans) begin
          state_nxt = vdp_pkg::VDP_ST_SEARCH;
        end
      end
      default: begin
        state_nxt = vdp_pkg::VDP_ST_OFF;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r <= vdp_pkg::VDP_ST_OFF;
    end else if (!s_pd_n) begin
      state_r <= vdp_pkg::VDP_ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // counts reference edges, lock then search
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_r <= '0;
    end else if (!s_pd_n || state_nxt != state_r || timeout) begin
      cnt_r <= '0;
    end else if (ref_rise) begin
      cnt_r <= cnt_r + CW'(1);
    end
  end

  // word sampled mid-period, where the decoder's data are settled
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hold_pix_r <= '0;
      hold_ctl_r <= '0;
      hold_video_r <= 1'b0;
    end else if (rec_fall) begin
      hold_pix_r <= s_pix;
      hold_ctl_r <= s_ctl;
      hold_video_r <= s_video;
    end
  end

  // falling launch uses the live word; rising launch the one held since
  assign src_pix = s_rf ? s_pix : hold_pix_r;
  assign src_ctl = s_rf ? s_ctl : hold_ctl_r;
  assign src_video = s_rf ? s_video : hold_video_r;

  // flag follows the phase of the word
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flag_r <= 1'b0;
      pix_r <= '0;
      ctl_r <= '0;
    end else if (!locked) begin
      flag_r <= 1'b0;
      pix_r <= '0;
      ctl_r <= '0;
    end else if (launch) begin
      flag_r <= src_video;
      // pixels update only in video phase
      if (src_video) begin
        pix_r <= src_pix;
      end else begin
        ctl_r <= src_ctl;
      end
    end
  end

  // clock edge matches the launch timing
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pclk_r <= 1'b0;
    end else if (locked) begin
      pclk_r <= s_rec;
    end else if (state_r == vdp_pkg::VDP_ST_OFF) begin
      pclk_r <= 1'b0;
    end else begin
      pclk_r <= s_ref;
    end
  end

  // valid only after a word has been launched
  // raised in the very cycle lock ends, so it never trails the data clear
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      valid_n_r <= 1'b1;
    end else if (!locked || state_nxt != vdp_pkg::VDP_ST_LOCKED || !s_pd_n) begin
      valid_n_r <= 1'b1;
    end else if (launch) begin
      valid_n_r <= 1'b0;
    end
  end

  // drive only when enabled and powered
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      oe_n_r <= 1'b1;
    end else begin
      oe_n_r <= ~(s_en & s_pd_n);
    end
  end

  // range code sets slew, flags bad codes
  assign rng_bad = ({s_rhi, s_rlo} != `VDP_RNG_SLOW) && ({s_rhi, s_rlo} != `VDP_RNG_FAST);
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      slew_r <= 1'b0;
      rng_bad_prev_r <= 1'b0;
    end else begin
      slew_r <= ({s_rhi, s_rlo} == `VDP_RNG_FAST);
      rng_bad_prev_r <= rng_bad & s_pd_n;
    end
  end

  // sticky events; a read clears, a new event in that cycle survives
  always_comb begin
    ev = '0;
    ev[`VDP_EV_LOCK_GAINED] = !locked && (state_nxt == vdp_pkg::VDP_ST_LOCKED) && s_pd_n;
    ev[`VDP_EV_LOCK_LOST] = locked && (state_nxt != vdp_pkg::VDP_ST_LOCKED || !s_pd_n);
    ev[`VDP_EV_SEARCH_TMO] = timeout;
    ev[`VDP_EV_RANGE_BAD] = rng_bad && s_pd_n && !rng_bad_prev_r;
    status_nxt = status_r;
    if (reg_rd_i && reg_addr_i == `VDP_OFS_STATUS) begin
      status_nxt = '0;
    end
    status_nxt = status_nxt | ev;
  end

  // status, mask and interrupt level
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      status_r <= `VDP_STATUS_RST;
      mask_r <= `VDP_MASK_RST;
      irq_r <= 1'b0;
    end else begin
      status_r <= status_nxt;
      if (reg_wr_i && reg_addr_i == `VDP_OFS_MASK) begin
        mask_r <= reg_wdata_i[`VDP_EV_W-1:0];
      end
      irq_r <= |(status_r & mask_r);
    end
  end

  // read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= '0;
      if (reg_rd_i) begin
        case (reg_addr_i)
          `VDP_OFS_STATUS: rdata_r[`VDP_EV_W-1:0] <= status_r;
          `VDP_OFS_MASK: rdata_r[`VDP_EV_W-1:0] <= mask_r;
          `VDP_OFS_INFO: begin
            rdata_r[`VDP_INFO_STATE_LSB +: 4] <= state_r;
            rdata_r[`VDP_INFO_FAST_SLEW] <= slew_r;
            rdata_r[`VDP_INFO_RISE_EDGE] <= s_rf;
            rdata_r[`VDP_INFO_DRIVING] <= ~oe_n_r;
          end
          default: rdata_r <= '0;
        endcase
      end
    end
  end

  assign pixel_word_out_o = pix_r;
  assign control_word_out_o = ctl_r;
  assign video_phase_flag_o = flag_r;
  assign pclk_out_o = pclk_r;
  assign sync_valid_n_o = valid_n_r;
  assign outputs_oe_n_o = oe_n_r;
  assign fast_slew_o = slew_r;
  assign reg_rdata_o = rdata_r;
  assign irq_o = irq_r;

  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  sequence launch_locked_s;
    locked && launch && state_nxt == vdp_pkg::VDP_ST_LOCKED && s_pd_n;
  endsequence

  sequence search_timeout_s;
    timeout && s_pd_n;
  endsequence

  ctl_hold_a: assert property (flag_r |-> $stable(ctl_r))
    else $error("control word changed in video phase");
  pix_hold_a: assert property ((!flag_r && !valid_n_r) |-> $stable(pix_r))
    else $error("pixel word changed in control phase");
  phase_flag_a: assert property (launch_locked_s |=> flag_r == $past(src_video))
    else $error("phase flag does not follow word phase");
  latch_edge_a: assert property (launch_locked_s |=> pclk_r == !$past(s_rf))
    else $error("data launched on the latch edge");
  launch_only_a: assert property ((locked && $past(locked) && $changed(pix_r))
    |-> $past(launch))
    else $error("pixel word changed away from launch edge");
  drive_off_a: assert property ((!s_en || !s_pd_n) |=> oe_n_r)
    else $error("outputs driven while disabled");
  valid_lock_a: assert property (!valid_n_r |-> locked)
    else $error("sync-valid low while unlocked");
  ref_forward_a: assert property ((state_r == vdp_pkg::VDP_ST_REF && s_pd_n)
    |=> pclk_r == $past(s_ref))
    else $error("reference clock not forwarded");
  tmo_restart_a: assert property (search_timeout_s |=> (state_r == vdp_pkg::VDP_ST_SEARCH
    && cnt_r == '0 && valid_n_r && status_r[`VDP_EV_SEARCH_TMO]))
    else $error("search timeout not handled");
  pd_stop_a: assert property (!s_pd_n |=> (state_r == vdp_pkg::VDP_ST_OFF
    && valid_n_r && oe_n_r))
    else $error("power-down did not stop the loop");
  slew_range_a: assert property (##1 slew_r == $past({s_rhi, s_rlo} == `VDP_RNG_FAST))
    else $error("slew does not follow range code");
  irq_level_a: assert property ((|(status_r & mask_r)) |=> irq_r)
    else $error("interrupt missing for unmasked event");

endmodule : vdp_deser_out
`default_nettype wire

// ### core/vdp_pkg.sv
/*
  vdp_pkg.sv: types of the parallel video output block.
  Assumes nothing beyond a SystemVerilog compiler; nothing is imported.
*/
package vdp_pkg;

  // lock sequence, one-hot
  typedef enum logic [3:0] {
    VDP_ST_OFF = 4'b0001,
    VDP_ST_REF = 4'b0010,
    VDP_ST_SEARCH = 4'b0100,
    VDP_ST_LOCKED = 4'b1000
  } vdp_state_t;

endpackage : vdp_pkg
